// [ocp_core.v]
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/10ps
// =====================================================
module ocp_core #(
  parameter CHANNEL = 1
) (
  input wire i_clk,
  input wire i_rst,
  input wire [2:0] i_addr,
  input wire [15:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [15:0] o_rdata,
  input wire [4:0] i_tmr_presc_tick,
  input wire [15:0] i_timer_count_value,
  input wire i_cpu_idle,
  input wire i_fault_pin_a,
  input wire i_fault_pin_b,
  input wire [2:0] i_cmp_out,
  input wire i_sync_evt,
  output reg o_compare_output_pin,
  output reg o_compare_event
);
  `include "ocp_regs.vh"

  // =====================================================
  // software visible state
  reg [15:0] con1_r;
  reg [15:0] con2_r;
  reg [15:0] pri_r;
  reg [15:0] sec_r;
  reg [15:0] per_r;
  reg [15:0] cnt_r;
  reg trun_r;
  reg [15:0] rdata_nxt;

  function [15:0] bits;
    input [15:0] v;
    input [15:0] m;
    begin
      bits = v & m;
    end
  endfunction

  wire [2:0] mode = con1_r[2:0];
  wire [2:0] tsel = con1_r[`OCP_TSEL_HI:`OCP_TSEL_LO];
  wire pwm = (mode == `OCP_M_EPWM) || (mode == `OCP_M_CPWM);
  wire [4:0] sync_sel = con2_r[`OCP_SYNC_HI:0];
  wire trig_mode = con2_r[`OCP_TRIG_BIT];
  wire wr_con1 = i_wr && (i_addr == `OCP_A_CON1);
  wire wr_con2 = i_wr && (i_addr == `OCP_A_CON2);

  // =====================================================
  // time base and faults
  wire tick;
  ocp_tick_sel u_tick (
    .i_sel(tsel),
    .i_tmr_presc_tick(i_tmr_presc_tick),
    .i_idle(i_cpu_idle),
    .i_idle_stop(con1_r[`OCP_IDLE_BIT]),
    .o_tick(tick)
  );

  // comparator grouping: channels 1-3, 4-6, 7-9
  wire cmp_src = (CHANNEL <= 3) ? i_cmp_out[0] :
                 (CHANNEL <= 6) ? i_cmp_out[1] : i_cmp_out[2];
  wire [2:0] flags;
  wire flt_act;
  wire [2:0] flt_clr = wr_con1 ? ~{i_wdata[`OCP_FLT_CMP], i_wdata[`OCP_FLT_B],
                                   i_wdata[`OCP_FLT_A]} : 3'h0;
  ocp_fault u_flt (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_pwm(pwm),
    .i_en({con1_r[`OCP_ENF_CMP], con1_r[`OCP_ENF_B], con1_r[`OCP_ENF_A]}),
    .i_src({cmp_src, i_fault_pin_b, i_fault_pin_a}),
    .i_clr(flt_clr),
    .o_flag_r(flags),
    .o_active(flt_act)
  );

  // =====================================================
  // counter, shadows and output
  reg [15:0] sh_pri_r;
  reg [15:0] sh_sec_r;
  reg down_r;
  reg done_r;
  reg [2:0] mode_q_r;
  wire self_sync = (sync_sel == `OCP_SYNC_SELF) && !trig_mode;
  // in edge pwm the counter resets on the timer period match
  wire per_end = (i_timer_count_value == per_r);
  wire run = (mode != `OCP_M_OFF) && tick && (!trig_mode || trun_r ||
             sync_sel == 5'h00);
  wire m_pri = run && (cnt_r == pri_r);
  wire m_sec = run && (cnt_r == sec_r);
  wire sec_ovr = (sh_sec_r > per_r);
  wire all_zero = (sh_pri_r == 16'h0000) && (sh_sec_r == 16'h0000) &&
                  (per_r == 16'h0000);
  reg pin_nxt;
  wire pwm_lvl = down_r ? (cnt_r > sh_pri_r) : (cnt_r < sh_pri_r);
  // counter restart: pwm or self sync at period, otherwise external sync in sync mode
  wire restart = (pwm || self_sync) ? per_end : (i_sync_evt && sync_sel != 5'h00
                 && !trig_mode);

  always @* begin
    pin_nxt = o_compare_output_pin;
    case (mode)
      `OCP_M_SLO: if (m_pri && !done_r) pin_nxt = 1'b1;
      `OCP_M_SHI: if (m_pri && !done_r) pin_nxt = 1'b0;
      `OCP_M_TOG: if (m_pri) pin_nxt = ~o_compare_output_pin;
      `OCP_M_DCP: begin
        if (m_pri) pin_nxt = 1'b1;
        else if (m_sec) pin_nxt = 1'b0;
      end
      `OCP_M_DSS: begin
        if (m_pri && !done_r) pin_nxt = 1'b1;
        else if (m_sec && o_compare_output_pin) pin_nxt = 1'b0;
      end
      `OCP_M_EPWM, `OCP_M_CPWM: begin
        if (all_zero) pin_nxt = 1'b0;
        else if (sec_ovr) pin_nxt = 1'b1;
        else pin_nxt = pwm_lvl;
        if (flt_act) pin_nxt = con2_r[`OCP_FLTOUT_BIT];
      end
      default: pin_nxt = 1'b0;
    endcase
  end

  always @(posedge i_clk) begin
    if (i_rst) begin
      cnt_r <= 16'h0000;
      sh_pri_r <= 16'h0000;
      sh_sec_r <= 16'h0000;
      down_r <= 1'b0;
      done_r <= 1'b0;
      mode_q_r <= 3'h0;
      o_compare_output_pin <= 1'b0;
      o_compare_event <= 1'b0;
    end else begin
      mode_q_r <= mode;
      o_compare_event <= pwm ? (run && per_end) :
                         ((mode[2] ? m_sec : m_pri) && !done_r);
      if (mode != mode_q_r) begin
        // entering a mode sets its idle level and rearms single shot
        done_r <= 1'b0;
        o_compare_output_pin <= (mode == `OCP_M_SHI);
        cnt_r <= 16'h0000;
        down_r <= 1'b0;
      end else begin
        o_compare_output_pin <= pin_nxt;
        if ((mode == `OCP_M_SLO || mode == `OCP_M_SHI) && m_pri)
          done_r <= 1'b1;
        if (mode == `OCP_M_DSS && m_sec && o_compare_output_pin)
          done_r <= 1'b1;
        if (run) begin
          if (pwm && per_end) begin
            // hidden shadows latch only at period end
            sh_pri_r <= pri_r;
            sh_sec_r <= sec_r;
          end
          if (mode == `OCP_M_CPWM) begin
            // center aligned counts up then down over the period
            if (!down_r && cnt_r >= per_r) begin
              down_r <= 1'b1;
              cnt_r <= cnt_r - 16'h0001;
            end else if (down_r && cnt_r == 16'h0000) begin
              down_r <= 1'b0;
              cnt_r <= 16'h0001;
            end else begin
              cnt_r <= down_r ? cnt_r - 16'h0001 : cnt_r + 16'h0001;
            end
          end else if (restart) begin
            cnt_r <= 16'h0000;
          end else begin
            cnt_r <= cnt_r + 16'h0001;
          end
        end
      end
    end
  end

  // =====================================================
  // register port
  always @(posedge i_clk) begin
    if (i_rst) begin
      con1_r <= `OCP_CON1_RST;
      con2_r <= `OCP_CON2_RST;
      pri_r <= 16'h0000;
      sec_r <= 16'h0000;
      per_r <= 16'h0000;
      trun_r <= 1'b0;
    end else begin
      if (wr_con1) con1_r <= bits(i_wdata, `OCP_CON1_MASK);
      if (wr_con2) con2_r <= bits(i_wdata, `OCP_CON2_MASK);
      if (i_wr && i_addr == `OCP_A_PRI) pri_r <= i_wdata;
      if (i_wr && i_addr == `OCP_A_SEC) sec_r <= i_wdata;
      if (i_wr && i_addr == `OCP_A_PER) per_r <= i_wdata;
      // trigger flag: sync event sets, and set wins over any clear
      if (trig_mode && i_sync_evt)
        trun_r <= 1'b1;
      else if (wr_con2)
        trun_r <= i_wdata[`OCP_TRUN_BIT];
      else if (con1_r[`OCP_TRIGMD_BIT] && run && cnt_r == sec_r)
        trun_r <= 1'b0;
    end
  end

  always @* begin
    case (i_addr)
      `OCP_A_CON1: rdata_nxt = {con1_r[15:7], flags, con1_r[3:0]};
      `OCP_A_CON2: rdata_nxt = {con2_r[15:7], trun_r, con2_r[5:0]};
      `OCP_A_PRI: rdata_nxt = pri_r;
      `OCP_A_SEC: rdata_nxt = sec_r;
      `OCP_A_PER: rdata_nxt = per_r;
      `OCP_A_CNT: rdata_nxt = cnt_r;
      default: rdata_nxt = 16'h0000;
    endcase
  end

  always @(posedge i_clk) begin
    if (i_rst)
      o_rdata <= 16'h0000;
    else if (i_rd)
      o_rdata <= rdata_nxt;
    else
      o_rdata <= 16'h0000;
  end
endmodule // ocp_core

// [ocp_core_assertions.sv]
`timescale 1ns/10ps
`include "ocp_regs.vh"
// ====
// port checker
module ocp_core_chk (
  input wire i_clk,
  input wire i_rst,
  input wire [2:0] i_addr,
  input wire [15:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [15:0] o_rdata,
  input wire [4:0] i_tmr_presc_tick,
  input wire [15:0] i_timer_count_value,
  input wire i_cpu_idle,
  input wire i_fault_pin_a,
  input wire i_fault_pin_b,
  input wire [2:0] i_cmp_out,
  input wire i_sync_evt,
  input wire o_compare_output_pin,
  input wire o_compare_event
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic [15:0] con1_r;
  logic [1:0] age_r;
  logic pin_d_r;
  logic done_r;
  wire [2:0] mode = con1_r[2:0];
  wire cwr = i_wr && i_addr == `OCP_A_CON1;
  // age lets a new mode settle before the pin is judged
  always @(posedge i_clk) begin
    pin_d_r <= o_compare_output_pin;
    if (i_rst || cwr) begin
      age_r <= 2'h0;
      done_r <= 1'b0;
    end else begin
      age_r <= (age_r == 2'h3) ? age_r : age_r + 2'h1;
      if (mode == `OCP_M_DSS && age_r == 2'h3 && pin_d_r && !o_compare_output_pin) begin
        done_r <= 1'b1;
      end
    end
    if (i_rst) begin
      con1_r <= 16'h0;
    end else if (cwr) begin
      con1_r <= i_wdata & 16'h3f8f;
    end
  end
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0)
    else $error("read data not zero outside read");
  a_unmapped_read: assert property ($past(i_rd) && $past(i_addr) > 3'h5 |-> o_rdata == 16'h0)
    else $error("unmapped read not zero");
  a_con1_readback: assert property (
    $past(i_rd) && $past(i_addr) == `OCP_A_CON1 |-> (o_rdata & 16'hff8f) == $past(con1_r))
    else $error("control one readback wrong");
  a_reset_quiet: assert property ($fell(i_rst) |-> !o_compare_output_pin && !o_compare_event)
    else $error("outputs active after reset");
  a_off_quiet: assert property (
    mode == `OCP_M_OFF && age_r == 2'h3 |-> !o_compare_output_pin && !o_compare_event)
    else $error("disabled channel active");
  a_shot_high_holds: assert property (
    mode == `OCP_M_SLO && age_r == 2'h3 && pin_d_r |-> o_compare_output_pin)
    else $error("single shot high not held");
  a_shot_low_holds: assert property (
    mode == `OCP_M_SHI && age_r == 2'h3 && !pin_d_r |-> !o_compare_output_pin)
    else $error("single shot low not held");
  a_dss_once: assert property (mode == `OCP_M_DSS && done_r |-> !o_compare_output_pin)
    else $error("second pulse in single shot");
endmodule // ocp_core_chk

bind ocp_core ocp_core_chk chk_i (.*);

// [ocp_far_side.sv]
`timescale 1ns/10ps
// ====
// far side: timer with prescaler ticks, fault sources
module ocp_far_side (
  input wire i_clk,
  input wire [15:0] i_per,
  input wire i_div2,
  input wire [4:0] i_mask,
  input wire [1:0] i_flt,
  output logic [4:0] o_tick,
  output logic [15:0] o_cnt,
  output logic o_fa,
  output logic o_fb
);
  logic ph_r = 1'b0;
  initial o_cnt = 16'h0;
  // the count only moves on a prescaler tick, so counter and timer agree
  assign o_tick = (ph_r | !i_div2) ? i_mask : 5'h0;
  always @(posedge i_clk) begin
    ph_r <= !ph_r;
    if (o_tick != 5'h0) begin
      o_cnt <= (o_cnt >= i_per) ? 16'h0 : o_cnt + 16'h1;
    end
  end
  assign o_fa = i_flt[0];
  assign o_fb = i_flt[1];
endmodule // ocp_far_side

// [ocp_fault.v]
`timescale 1ns/10ps
// =====================================================
// fault qualify and sticky flags
module ocp_fault (
  input wire i_clk,
  input wire i_rst,
  input wire i_pwm,
  input wire [2:0] i_en,
  input wire [2:0] i_src,
  input wire [2:0] i_clr,
  output reg [2:0] o_flag_r,
  output wire o_active
);
  wire [2:0] hit;
  assign hit = i_src & i_en & {3{i_pwm}};
  assign o_active = |hit;
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_flag_r <= 3'h0;
    end else begin
      // a live fault wins over a software clear
      o_flag_r <= (o_flag_r & ~i_clr) | hit;
    end
  end
endmodule // ocp_fault

// [ocp_regs.vh]
`ifndef OCP_REGS_VH
`define OCP_REGS_VH
// register indices on the plain port (word addresses)
`define OCP_ADDR_W 3
`define OCP_A_CON1 3'h0
`define OCP_A_CON2 3'h1
`define OCP_A_PRI 3'h2
`define OCP_A_SEC 3'h3
`define OCP_A_PER 3'h4
`define OCP_A_CNT 3'h5
// control one fields
`define OCP_IDLE_BIT 13
`define OCP_TSEL_HI 12
`define OCP_TSEL_LO 10
`define OCP_ENF_CMP 9
`define OCP_ENF_B 8
`define OCP_ENF_A 7
`define OCP_FLT_CMP 6
`define OCP_FLT_B 5
`define OCP_FLT_A 4
`define OCP_TRIGMD_BIT 3
`define OCP_CON1_MASK 16'h3fff
`define OCP_CON1_RST 16'h0000
// control two fields
`define OCP_FLTOUT_BIT 14
`define OCP_TRIG_BIT 7
`define OCP_TRUN_BIT 6
`define OCP_SYNC_HI 4
`define OCP_CON2_MASK 16'h40df
`define OCP_CON2_RST 16'h000c
`define OCP_SYNC_SELF 5'h1f
// time base codes
`define OCP_TB_T2 3'h0
`define OCP_TB_T3 3'h1
`define OCP_TB_T4 3'h2
`define OCP_TB_T5 3'h3
`define OCP_TB_T1 3'h4
`define OCP_TB_PCLK 3'h7
// modes
`define OCP_M_OFF 3'h0
`define OCP_M_SLO 3'h1
`define OCP_M_SHI 3'h2
`define OCP_M_TOG 3'h3
`define OCP_M_DSS 3'h4
`define OCP_M_DCP 3'h5
`define OCP_M_EPWM 3'h6
`define OCP_M_CPWM 3'h7
`endif

// [ocp_tick_sel.v]
`timescale 1ns/10ps
// =====================================================
// time base tick select
module ocp_tick_sel (
  input wire [2:0] i_sel,
  input wire [4:0] i_tmr_presc_tick,
  input wire i_idle,
  input wire i_idle_stop,
  output wire o_tick
);
  `include "ocp_regs.vh"
  reg t;
  // prescaler outputs, not the timers' count outputs, drive the counter
  always @* begin
    case (i_sel)
      `OCP_TB_T2: t = i_tmr_presc_tick[0];
      `OCP_TB_T3: t = i_tmr_presc_tick[1];
      `OCP_TB_T4: t = i_tmr_presc_tick[2];
      `OCP_TB_T5: t = i_tmr_presc_tick[3];
      `OCP_TB_T1: t = i_tmr_presc_tick[4];
      `OCP_TB_PCLK: t = 1'b1;
      default: t = 1'b0; // reserved codes give no time base
    endcase
  end
  assign o_tick = t & ~(i_idle & i_idle_stop);
endmodule // ocp_tick_sel

// [tb.sv]
`timescale 1ns/10ps
`include "ocp_regs.vh"
// ====
// bench
module tb;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [2:0] i_addr = 3'h0;
  logic [15:0] i_wdata = 16'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_cpu_idle = 1'b0;
  logic [2:0] i_cmp_out = 3'h0;
  logic i_sync_evt = 1'b0;
  logic [15:0] per_r = 16'h0;
  logic div_r = 1'b0;
  logic [4:0] mask_r = 5'h1f;
  logic [1:0] flt_r = 2'h0;
  logic [15:0] o_rdata;
  logic [4:0] i_tmr_presc_tick;
  logic [15:0] i_timer_count_value;
  logic i_fault_pin_a;
  logic i_fault_pin_b;
  logic o_compare_output_pin;
  logic o_compare_event;
  logic [15:0] v;
  int ev;
  int n_mismatch = 0;
  int cmp_count = 0;
  ocp_core #(.CHANNEL(1)) dut (.*);
  ocp_far_side far_i (.i_clk(i_clk), .i_per(per_r), .i_div2(div_r), .i_mask(mask_r),
    .i_flt(flt_r), .o_tick(i_tmr_presc_tick), .o_cnt(i_timer_count_value),
    .o_fa(i_fault_pin_a), .o_fb(i_fault_pin_b));
  always #25 i_clk = !i_clk;
  // ====
  // tasks
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [15:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    chk(o_rdata, e);
  endtask
  task automatic setr(input logic [15:0] p, input logic [15:0] s, input logic [15:0] n);
    wr(`OCP_A_PRI, p);
    wr(`OCP_A_SEC, s);
    wr(`OCP_A_PER, n);
    per_r <= n;
  endtask
  task automatic meas(output int r, output int h);
    logic p;
    r = 0;
    h = 0;
    p = o_compare_output_pin;
    repeat (80) begin
      @(negedge i_clk);
      r += (o_compare_output_pin & !p);
      h += o_compare_output_pin;
      p = o_compare_output_pin;
    end
  endtask
  task automatic run(input logic [15:0] c, input logic idl, input logic d2,
      input logic [4:0] m, input logic [15:0] er, input logic [15:0] eh);
    int r;
    int h;
    @(posedge i_clk);
    i_cpu_idle <= idl;
    div_r <= d2;
    mask_r <= m;
    wr(`OCP_A_CON1, c);
    repeat (24) @(posedge i_clk);
    meas(r, h);
    chk(r[15:0], er);
    if (eh != 16'hffff) chk(h[15:0], eh);
    $display("test done con1 %h", c);
  endtask
  // ====
  // watchdog and main sequence
  initial begin
    repeat (20000) @(posedge i_clk);
    n_mismatch++;
    final_report;
  end
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(`OCP_A_CON1, 16'h0);
    rd(`OCP_A_CON2, 16'h000c);
    wr(3'h6, 16'hffff);
    rd(3'h6, 16'h0);
    wr(`OCP_A_CON1, 16'hc000);
    rd(`OCP_A_CON1, 16'h0);
    wr(`OCP_A_CON2, 16'h001f);
    rd(`OCP_A_CON2, 16'h001f);
    setr(16'h2, 16'h5, 16'h7);
    run(16'h1c00, 0, 0, 5'h1f, 0, 0);
    run(16'h1c01, 0, 0, 5'h1f, 0, 80);
    run(16'h1c02, 0, 0, 5'h1f, 0, 0);
    run(16'h1c03, 0, 0, 5'h1f, 5, 40);
    run(16'h1c04, 0, 0, 5'h1f, 0, 0);
    run(16'h1c05, 0, 0, 5'h1f, 10, 16'hffff);
    run(16'h1c06, 0, 0, 5'h1f, 10, 20);
    // one period-end pulse per eight-tick period
    ev = 0;
    repeat (80) begin
      @(negedge i_clk);
      ev += o_compare_event;
    end
    chk(ev[15:0], 16'h000a);
    run(16'h3c03, 1, 0, 5'h1f, 0, 16'hffff);
    run(16'h1c03, 1, 0, 5'h1f, 5, 40);
    run(16'h0006, 0, 1, 5'h01, 5, 20);
    run(16'h0c06, 0, 1, 5'h08, 5, 20);
    run(16'h1006, 0, 1, 5'h10, 5, 20);
    run(16'h0006, 0, 1, 5'h02, 0, 16'hffff);
    setr(16'h2, 16'h9, 16'h7);
    rd(`OCP_A_SEC, 16'h9);
    run(16'h1c86, 0, 0, 5'h1f, 0, 80);
    flt_r <= 2'b10;
    repeat (4) @(posedge i_clk);
    rd(`OCP_A_CON1, 16'h1c86);
    @(posedge i_clk);
    flt_r <= 2'b11;
    repeat (4) @(posedge i_clk);
    run(16'h1c86, 0, 0, 5'h1f, 0, 0);
    rd(`OCP_A_CON1, 16'h1c96);
    @(posedge i_clk);
    flt_r <= 2'b00;
    repeat (3) @(posedge i_clk);
    wr(`OCP_A_CON1, 16'h1e06);
    i_cmp_out <= 3'b010;
    repeat (4) @(posedge i_clk);
    rd(`OCP_A_CON1, 16'h1e06);
    i_cmp_out <= 3'b001;
    repeat (4) @(posedge i_clk);
    rd(`OCP_A_CON1, 16'h1e46);
    i_cmp_out <= 3'b000;
    repeat (3) @(posedge i_clk);
    wr(`OCP_A_CON1, 16'h1f83);
    flt_r <= 2'b11;
    i_cmp_out <= 3'b001;
    repeat (4) @(posedge i_clk);
    rd(`OCP_A_CON1, 16'h1f83);
    // trigger mode with the running flag set by software, hardware clear on match
    wr(`OCP_A_CON2, 16'h00df);
    rd(`OCP_A_CON2, 16'h00df);
    wr(`OCP_A_CON1, 16'h1c0d);
    repeat (20) @(posedge i_clk);
    rd(`OCP_A_CON2, 16'h009f);
    wr(`OCP_A_CON2, 16'h001f);
    flt_r <= 2'b00;
    i_cmp_out <= 3'b000;
    setr(16'h0, 16'h0, 16'h0);
    run(16'h1c06, 0, 0, 5'h1f, 0, 0);
    final_report;
  end
endmodule // tb
